/* File: design/tcp_regs.svh */
// Register offsets, field positions and constants of the PWM timer
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TCP_ADDR_ENABLE   8'h60
`define TCP_ADDR_POLARITY 8'h61
`define TCP_ADDR_PRESCALE 8'h62
`define TCP_ADDR_CONTROL  8'h63
`define TCP_ADDR_CNT0     8'h64
`define TCP_ADDR_CNT1     8'h65
`define TCP_ADDR_PER0     8'h66
`define TCP_ADDR_PER1     8'h67
`define TCP_ADDR_DTY0     8'h68
`define TCP_ADDR_DTY1     8'h69
`define TCP_ADDR_SCALE_A  8'h6a
`define TCP_ADDR_SCALE_B  8'h6b

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TCP_PCKA_LSB      0
`define TCP_PCKB_LSB      4
`define TCP_PCK_W         3
`define TCP_CLKSEL_LSB    0
`define TCP_CAE_LSB       4
`define TCP_CHAN_W        2

// ----------------------------------------
// Values and counts
// ----------------------------------------
`define TCP_ZERO          8'h00
`define TCP_ONE           8'h01
`define TCP_SCALE_TERM    8'h01
`define TCP_PRESC_STEP    7'h01

`endif

/* File: design/tcp_pkg.sv */
// Types shared by the PWM timer design
package tcp_pkg;

   // ----------------------------------------
   // Channel and block state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] per_buf;
      logic [7:0] dty_buf;
      logic [7:0] per;
      logic [7:0] dty;
      logic       dir_down;
      logic       phase;
   } tcp_chan_t;

   typedef struct packed {
      logic [6:0]      presc;
      logic [7:0]      sa_cnt;
      logic [7:0]      sb_cnt;
      logic            sa_div;
      logic            sb_div;
      tcp_chan_t [1:0] ch;
      logic [1:0]      en;
      logic [1:0]      pol;
      logic [1:0]      clksel;
      logic [1:0]      cae;
      logic [2:0]      pck_a;
      logic [2:0]      pck_b;
      logic [7:0]      scl_a;
      logic [7:0]      scl_b;
      logic [1:0]      pwm;
      logic [7:0]      rdata;
   } tcp_state_t;

endpackage

/* File: design/tcp_pwm_timer.sv */
// Two-channel 8-bit PWM timer with prescaler, scaled clocks and register port
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "tcp_regs.svh"
// Operation
// RQ1: Scaled B clock is clock B over twice the scale value; zero means 256.
// RQ2: Scaled B comes from an 8-bit reloading down counter then divide by two.
// RQ3: Writing a scale register reloads its down counter at once.
// RQ4: Channel 0 uses clock A or scaled A, channel 1 clock B or scaled B.
// RQ5: Each channel has 8-bit counter, period, duty; duty match toggles output.
// RQ6: Enable acts at once, waveform starts at next tick of selected clock.
// RQ7: Enable gates the channel clock at tick edges; disabled counter holds.
// RQ8: Polarity set starts high, low at duty; cleared starts low, high at duty.
// RQ9: While enabled, period and duty writes wait in buffers until a reload.
// RQ10: While disabled, period and duty writes update buffer and active copy.
// RQ11: Counter write clears count, sets up, loads buffers, sets output.
// RQ12: Counter reads return the count and disturb nothing.
// RQ13: Disable freezes the counter; re-enable resumes from the held value.
// RQ14: Disabled with period zero, the counter clears on the next tick.
// RQ15: The counter clears at the end of each effective period.
// RQ16: Alignment bit cleared gives left aligned output, up counting only.
// RQ17: Left aligned period match restarts count, output and loads buffers.
// RQ18: Left aligned frequency is tick rate over period; duty per polarity.
// RQ19: Software writes the counter before enabling for a clean waveform.
// RQ20: Software sets alignment mode before enabling a channel.
// RQ21: Center aligned counts up to period, down to zero, reloads at zero.
// RQ22: Zero duty or zero period hold the output at fixed polarity levels.
// RQ23: After reset counters count up, channels disabled, nothing counts; the prescaler and the scale down counters still run after reset.
// RQ24: Clocks A and B are bus clock over 1 to 128 by 3-bit fields.

module tcp_pwm_timer
   import tcp_pkg::*;
(
   input  wire logic       I_REF_CLK,
   input  wire logic       I_RST,
   input  wire logic [7:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output logic      [7:0] O_RDATA,
   output logic      [1:0] O_PWM
);

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Clock A/B tick: one bus cycle in every 2**sel
   function automatic logic div_tick(input logic [6:0] p,
                                     input logic [2:0] sel);
      logic [6:0] m;
      m = 7'((`TCP_ONE << sel) - `TCP_ONE);
      return (p & m) == m;
   endfunction

   // Down counter step: {pulse, next count}; a zero load wraps to 256 counts
   function automatic logic [8:0] scale_step(input logic [7:0] c,
                                             input logic [7:0] scl,
                                             input logic       tk);
      logic [8:0] r;
      r = {1'b0, c};
      if (tk) begin
         if (c == `TCP_SCALE_TERM) begin
            r = {1'b1, scl};
         end else begin
            r = {1'b0, 8'(c - `TCP_ONE)};
         end
      end
      return r;
   endfunction

   // One channel, one bus cycle; tk is the selected channel clock tick
   function automatic tcp_chan_t chan_step(input tcp_chan_t c,
                                           input logic      en,
                                           input logic      cae,
                                           input logic      tk);
      tcp_chan_t n;
      logic      restart;
      n       = c;
      restart = 1'b0;
      if (!en) begin // RQ13
         // Disabled: active copy follows the buffers, count holds unless a tick clears it at period zero
         n.per = c.per_buf; // RQ10
         n.dty = c.dty_buf;
         if (tk && c.per == `TCP_ZERO) begin
            n.cnt = `TCP_ZERO; // RQ14
         end
      end else if (tk) begin // RQ7
         if (c.per == `TCP_ZERO) begin
            n.cnt      = `TCP_ZERO; // RQ22
            n.dir_down = 1'b0;
         end else if (!cae) begin
            n.dir_down = 1'b0; // RQ16
            if (c.cnt >= 8'(c.per - `TCP_ONE)) begin // RQ18
               restart = 1'b1; // RQ17
            end else begin
               n.cnt = 8'(c.cnt + `TCP_ONE);
            end
         end else if (!c.dir_down) begin
            if (c.cnt >= c.per) begin
               n.dir_down = 1'b1; // RQ21
               n.cnt      = 8'(c.cnt - `TCP_ONE);
               restart    = (n.cnt == `TCP_ZERO);
            end else begin
               n.cnt = 8'(c.cnt + `TCP_ONE);
            end
         end else begin
            if (c.cnt != `TCP_ZERO) begin
               n.cnt = 8'(c.cnt - `TCP_ONE);
            end
            restart = (n.cnt == `TCP_ZERO); // RQ21
         end
         if (restart) begin
            n.cnt      = `TCP_ZERO; // RQ15
            n.dir_down = 1'b0;
            n.per      = c.per_buf;
            n.dty      = c.dty_buf;
            n.phase    = (c.dty_buf == `TCP_ZERO);
         end else if (n.cnt == c.dty && c.dty != `TCP_ZERO
                      && c.dty < c.per) begin
            // Match only inside the period, so duty >= period never toggles
            n.phase = ~c.phase; // RQ5
         end
      end
      return n;
   endfunction

   // ----------------------------------------
   // State and decode
   // ----------------------------------------
   tcp_state_t s;
   tcp_state_t next_s;
   logic       tick_a;
   logic       tick_b;
   logic [8:0] step_a;
   logic [8:0] step_b;
   logic       stick_a;
   logic       stick_b;
   logic [1:0] tick_ch;
   logic [1:0] wr_cnt;
   logic [1:0] wr_per;
   logic [1:0] wr_dty;
   logic       wr_scl_a;
   logic       wr_scl_b;

   assign tick_a   = div_tick(s.presc, s.pck_a); // RQ24
   assign tick_b   = div_tick(s.presc, s.pck_b);
   assign step_a   = scale_step(s.sa_cnt, s.scl_a, tick_a);
   assign step_b   = scale_step(s.sb_cnt, s.scl_b, tick_b); // RQ2
   // Divide the pulse stream by two
   assign stick_a  = step_a[8] & s.sa_div;
   assign stick_b  = step_b[8] & s.sb_div; // RQ1
   assign tick_ch  = {s.clksel[1] ? stick_b : tick_b,
                      s.clksel[0] ? stick_a : tick_a}; // RQ4
   assign wr_cnt   = {I_WR && I_ADDR == `TCP_ADDR_CNT1,
                      I_WR && I_ADDR == `TCP_ADDR_CNT0};
   assign wr_per   = {I_WR && I_ADDR == `TCP_ADDR_PER1,
                      I_WR && I_ADDR == `TCP_ADDR_PER0};
   assign wr_dty   = {I_WR && I_ADDR == `TCP_ADDR_DTY1,
                      I_WR && I_ADDR == `TCP_ADDR_DTY0};
   assign wr_scl_a = I_WR && I_ADDR == `TCP_ADDR_SCALE_A;
   assign wr_scl_b = I_WR && I_ADDR == `TCP_ADDR_SCALE_B;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_s        = s;
      // Prescaler runs free; gating it would save power only
      next_s.presc  = 7'(s.presc + `TCP_PRESC_STEP);
      next_s.sa_cnt = step_a[7:0];
      next_s.sb_cnt = step_b[7:0];
      if (step_a[8]) begin
         next_s.sa_div = ~s.sa_div;
      end
      if (step_b[8]) begin
         next_s.sb_div = ~s.sb_div;
      end
      if (wr_scl_a) begin
         next_s.scl_a  = I_WDATA;
         next_s.sa_cnt = I_WDATA; // RQ3
      end
      if (wr_scl_b) begin
         next_s.scl_b  = I_WDATA;
         next_s.sb_cnt = I_WDATA; // RQ3
      end
      if (I_WR) begin
         unique case (I_ADDR)
            `TCP_ADDR_ENABLE: begin
               next_s.en = I_WDATA[`TCP_CHAN_W-1:0]; // RQ6
            end
            `TCP_ADDR_POLARITY: begin
               next_s.pol = I_WDATA[`TCP_CHAN_W-1:0];
            end
            `TCP_ADDR_PRESCALE: begin
               next_s.pck_a = I_WDATA[`TCP_PCKA_LSB +: `TCP_PCK_W];
               next_s.pck_b = I_WDATA[`TCP_PCKB_LSB +: `TCP_PCK_W];
            end
            `TCP_ADDR_CONTROL: begin
               next_s.clksel = I_WDATA[`TCP_CLKSEL_LSB +: `TCP_CHAN_W];
               next_s.cae    = I_WDATA[`TCP_CAE_LSB +: `TCP_CHAN_W];
            end
            default: begin
            end
         endcase
      end
      for (int i = 0; i < 2; i++) begin
         next_s.ch[i] = chan_step(s.ch[i], s.en[i], s.cae[i], tick_ch[i]);
         if (wr_per[i]) begin
            next_s.ch[i].per_buf = I_WDATA; // RQ9
            if (!s.en[i]) begin
               next_s.ch[i].per = I_WDATA; // RQ10
            end
         end
         if (wr_dty[i]) begin
            next_s.ch[i].dty_buf = I_WDATA;
            if (!s.en[i]) begin
               next_s.ch[i].dty = I_WDATA; // RQ10
            end
         end
         if (wr_cnt[i]) begin
            next_s.ch[i].cnt      = `TCP_ZERO; // RQ11
            next_s.ch[i].dir_down = 1'b0;
            next_s.ch[i].per      = s.ch[i].per_buf;
            next_s.ch[i].dty      = s.ch[i].dty_buf;
            next_s.ch[i].phase    = (s.ch[i].dty_buf == `TCP_ZERO);
         end
         // Output follows phase and polarity; no period pins it to polarity
         if (next_s.ch[i].per == `TCP_ZERO) begin
            next_s.pwm[i] = next_s.pol[i]; // RQ22
         end else begin
            next_s.pwm[i] = next_s.ch[i].phase ^ next_s.pol[i]; // RQ8
         end
      end
      next_s.rdata = `TCP_ZERO;
      if (I_RD) begin
         unique case (I_ADDR)
            `TCP_ADDR_ENABLE:   next_s.rdata = {6'h00, s.en};
            `TCP_ADDR_POLARITY: next_s.rdata = {6'h00, s.pol};
            `TCP_ADDR_PRESCALE: next_s.rdata = {1'b0, s.pck_b, 1'b0, s.pck_a};
            `TCP_ADDR_CONTROL:  next_s.rdata = {2'h0, s.cae, 2'h0, s.clksel};
            `TCP_ADDR_CNT0:     next_s.rdata = s.ch[0].cnt; // RQ12
            `TCP_ADDR_CNT1:     next_s.rdata = s.ch[1].cnt;
            `TCP_ADDR_PER0:     next_s.rdata = s.ch[0].per_buf;
            `TCP_ADDR_PER1:     next_s.rdata = s.ch[1].per_buf;
            `TCP_ADDR_DTY0:     next_s.rdata = s.ch[0].dty_buf;
            `TCP_ADDR_DTY1:     next_s.rdata = s.ch[1].dty_buf;
            `TCP_ADDR_SCALE_A:  next_s.rdata = s.scl_a;
            `TCP_ADDR_SCALE_B:  next_s.rdata = s.scl_b;
            default:            next_s.rdata = `TCP_ZERO;
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         s <= '0; // RQ23
      end else begin
         s <= next_s;
      end
   end

   assign O_RDATA = s.rdata;
   assign O_PWM   = s.pwm;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_RST);

   property p_scale_reload;
      wr_scl_b |=> s.sb_cnt == $past(I_WDATA);
   endproperty
   a_scale_reload: assert property (p_scale_reload) // RQ3
      else $error("scale write did not reload down counter");

   property p_scale_term;
      tick_a && s.sa_cnt == `TCP_SCALE_TERM && !wr_scl_a
         |=> s.sa_cnt == s.scl_a && s.sa_div != $past(s.sa_div);
   endproperty
   a_scale_term: assert property (p_scale_term) // RQ2
      else $error("scale counter did not reload at terminal count");

   property p_hold_disabled;
      !s.en[0] && !wr_cnt[0] && s.ch[0].per != `TCP_ZERO
         |=> $stable(s.ch[0].cnt);
   endproperty
   a_hold_disabled: assert property (p_hold_disabled) // RQ13
      else $error("disabled counter moved");

   property p_cnt_write;
      wr_cnt[1] |=> s.ch[1].cnt == `TCP_ZERO && !s.ch[1].dir_down
         && s.ch[1].per == $past(s.ch[1].per_buf);
   endproperty
   a_cnt_write: assert property (p_cnt_write) // RQ11
      else $error("counter write did not restart channel");

   property p_buffered;
      s.en[0] && !tick_ch[0] && !wr_cnt[0] |=> $stable(s.ch[0].per)
         && $stable(s.ch[0].dty);
   endproperty
   a_buffered: assert property (p_buffered) // RQ9
      else $error("active period changed without reload");

   property p_direct;
      !s.en[1] && wr_dty[1] |=> s.ch[1].dty == $past(I_WDATA);
   endproperty
   a_direct: assert property (p_direct) // RQ10
      else $error("disabled duty write not applied");

   property p_left_wrap;
      s.en[0] && !s.cae[0] && tick_ch[0] && !wr_cnt[0]
         && s.ch[0].per != `TCP_ZERO
         && s.ch[0].cnt >= 8'(s.ch[0].per - `TCP_ONE)
         |=> s.ch[0].cnt == `TCP_ZERO && s.ch[0].per == $past(s.ch[0].per_buf);
   endproperty
   a_left_wrap: assert property (p_left_wrap) // RQ17
      else $error("left aligned period end did not restart");

   property p_center_turn;
      s.en[0] && s.cae[0] && s.ch[0].dir_down && tick_ch[0] && !wr_cnt[0]
         && s.ch[0].cnt == `TCP_ONE
         |=> s.ch[0].cnt == `TCP_ZERO && !s.ch[0].dir_down;
   endproperty
   a_center_turn: assert property (p_center_turn) // RQ21
      else $error("center aligned counter did not turn at zero");

   property p_read_cnt;
      I_RD && I_ADDR == `TCP_ADDR_CNT0 |=> O_RDATA == $past(s.ch[0].cnt);
   endproperty
   a_read_cnt: assert property (p_read_cnt) // RQ12
      else $error("counter read returned wrong value");

   property p_no_period;
      s.ch[0].per == `TCP_ZERO && s.en[0] && $stable(s.pol[0])
         ##1 s.ch[0].per == `TCP_ZERO |-> O_PWM[0] == s.pol[0]
         && s.ch[0].cnt == `TCP_ZERO;
   endproperty
   a_no_period: assert property (p_no_period) // RQ22
      else $error("zero period output or counter wrong");

endmodule

/* File: test/tcp_load_model.sv */
// Load model on one PWM pin: measures period and high time per waveform cycle
`timescale 1ns/1ps
module tcp_load_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_pin,
   output logic      [15:0] o_period,
   output logic      [15:0] o_high,
   output logic             o_rise
);
   logic        prev;
   logic [15:0] cnt;
   logic [15:0] hcnt;

   // ----------------------------------------
   // Measurement
   // ----------------------------------------
   // A rising edge closes one cycle; its own high sample opens the next
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prev     <= 1'b0;
         cnt      <= 16'h0000;
         hcnt     <= 16'h0000;
         o_period <= 16'h0000;
         o_high   <= 16'h0000;
         o_rise   <= 1'b0;
      end else begin
         prev   <= i_pin;
         o_rise <= i_pin & ~prev;
         if (i_pin & ~prev) begin
            o_period <= cnt;
            o_high   <= hcnt;
            cnt      <= 16'h0001;
            hcnt     <= 16'h0001;
         end else begin
            cnt  <= cnt + 16'h0001;
            hcnt <= hcnt + {15'h0000, i_pin};
         end
      end
   end
endmodule

/* File: test/tcp_pwm_timer_tb.sv */
// Self-checking testbench of the two-channel PWM timer
`timescale 1ns/1ps
`include "tcp_regs.svh"
module tcp_pwm_timer_tb;
   import tcp_pkg::*;
   logic        clk   = 1'b0;
   logic        rst   = 1'b1;
   logic [7:0]  addr  = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr    = 1'b0;
   logic        rd    = 1'b0;
   logic        rd_q  = 1'b0;
   logic [7:0]  rdata;
   logic [1:0]  pwm;
   logic [15:0] per_m [2];
   logic [15:0] hi_m [2];
   logic [1:0]  rise;
   logic [31:0] w_note;
   logic [7:0]  v;
   logic [7:0]  exp_rd [$];
   logic [31:0] exp_wv [$];
   int          mismatches = 0;
   int          tests_run  = 0;
   int          i;
   int          s;

   always #5 clk = ~clk;

   tcp_pwm_timer uut (
      .I_REF_CLK (clk),
      .I_RST     (rst),
      .I_ADDR    (addr),
      .I_WDATA   (wdata),
      .I_WR      (wr),
      .I_RD      (rd),
      .O_RDATA   (rdata),
      .O_PWM     (pwm)
   );

   tcp_load_model u_load0 (.i_clk(clk), .i_rst(rst), .i_pin(pwm[0]),
      .o_period(per_m[0]), .o_high(hi_m[0]), .o_rise(rise[0]));
   tcp_load_model u_load1 (.i_clk(clk), .i_rst(rst), .i_pin(pwm[1]),
      .o_period(per_m[1]), .o_high(hi_m[1]), .o_rise(rise[1]));

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Notes are taken off in order as reads answer and waveform cycles close
   always @(posedge clk) begin
      rd_q <= rd;
      if (rd_q)
         check("read data", 32'(rdata), 32'(exp_rd.pop_front()));
      if (exp_wv.size() > 0) begin
         w_note = exp_wv[0];
         if (rise[w_note[31]]) begin
            void'(exp_wv.pop_front());
            check("period", 32'(per_m[w_note[31]]), 32'(w_note[30:16]));
            check("high time", 32'(hi_m[w_note[31]]), 32'(w_note[15:0]));
         end
      end
   end

   // ----------------------------------------
   // Bus and waveform tasks
   // ----------------------------------------
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      wr    <= 1'b1;
      rd    <= 1'b0;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
   endtask

   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      wr   <= 1'b0;
      rd   <= 1'b1;
      addr <= a;
      exp_rd.push_back(e);
      @(posedge clk);
   endtask

   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   // Counter written before enable so no history leaks in
   task automatic start(input int ch, input logic [7:0] p, input logic [7:0] d);
      wreg(`TCP_ADDR_ENABLE, 8'h00);
      wreg(`TCP_ADDR_PER0 + 8'(ch), p);
      wreg(`TCP_ADDR_DTY0 + 8'(ch), d);
      wreg(`TCP_ADDR_CNT0 + 8'(ch), 8'h5a);
      wreg(`TCP_ADDR_ENABLE, 8'(1 << ch));
   endtask

   // The first cycle after enabling may be irregular, so it is skipped
   task automatic measure(input int ch, input int p, input int h);
      int n;
      int k;
      n = 0;
      idle(0);
      for (k = 0; k < 8000 && n < 3; k++) begin
         @(posedge clk);
         if (rise[ch]) begin
            n++;
            if (n == 2) begin
               @(negedge clk);
               exp_wv.push_back({ch[0], p[14:0], h[15:0]});
            end
         end
      end
      check("pwm edges", 32'(n), 32'h3);
      if (n < 3) begin
         summarize();
      end
   endtask

   task automatic hold(input int ch, input logic lvl, input int n);
      repeat (n) begin
         @(posedge clk);
         check("held level", 32'(pwm[ch]), 32'(lvl));
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h9281778b));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("pwm after reset", 32'(pwm), 32'h0);
      for (i = 0; i < 12; i++)
         rreg(8'h60 + 8'(i), 8'h00);
      rreg(8'h70, 8'h00);
      $display("test reset values done");

      v = 8'($urandom());
      wreg(`TCP_ADDR_POLARITY, v);
      wreg(`TCP_ADDR_PRESCALE, v);
      wreg(`TCP_ADDR_CONTROL, v);
      wreg(`TCP_ADDR_SCALE_A, v);
      wreg(`TCP_ADDR_PER1, v);
      wreg(`TCP_ADDR_DTY1, v);
      wreg(8'h70, v);
      wreg(`TCP_ADDR_CNT1, v);
      rreg(`TCP_ADDR_POLARITY, v & 8'h03);
      rreg(`TCP_ADDR_PRESCALE, v & 8'h77);
      rreg(`TCP_ADDR_CONTROL, v & 8'h33);
      rreg(`TCP_ADDR_SCALE_A, v);
      rreg(`TCP_ADDR_PER1, v);
      rreg(`TCP_ADDR_DTY1, v);
      rreg(8'h70, 8'h00);
      rreg(`TCP_ADDR_CNT1, 8'h00);
      wreg(`TCP_ADDR_POLARITY, 8'h00);
      wreg(`TCP_ADDR_PRESCALE, 8'h00);
      wreg(`TCP_ADDR_CONTROL, 8'h00);
      $display("test register access done");

      start(0, 8'h04, 8'h01);
      measure(0, 4, 3);
      wreg(`TCP_ADDR_POLARITY, 8'h01);
      start(0, 8'h04, 8'h01);
      measure(0, 4, 1);
      wreg(`TCP_ADDR_PER0, 8'h08);
      wreg(`TCP_ADDR_DTY0, 8'h02);
      rreg(`TCP_ADDR_PER0, 8'h08);
      measure(0, 8, 2);
      $display("test left aligned done");

      wreg(`TCP_ADDR_ENABLE, 8'h00);
      wreg(`TCP_ADDR_CNT0, 8'h33);
      idle(20);
      rreg(`TCP_ADDR_CNT0, 8'h00);
      idle(2);
      hold(0, 1'b1, 8);
      // Run four ticks, stop, and the count must stay put until period zero clears it
      wreg(`TCP_ADDR_ENABLE, 8'h01);
      idle(3);
      wreg(`TCP_ADDR_ENABLE, 8'h00);
      idle(5);
      rreg(`TCP_ADDR_CNT0, 8'h04);
      wreg(`TCP_ADDR_PER0, 8'h00);
      idle(2);
      rreg(`TCP_ADDR_CNT0, 8'h00);
      start(0, 8'h04, 8'h00);
      idle(3);
      hold(0, 1'b0, 20);
      wreg(`TCP_ADDR_POLARITY, 8'h00);
      start(0, 8'h04, 8'h00);
      idle(3);
      hold(0, 1'b1, 20);
      wreg(`TCP_ADDR_POLARITY, 8'h01);
      start(0, 8'h00, 8'h02);
      idle(3);
      hold(0, 1'b1, 20);
      rreg(`TCP_ADDR_CNT0, 8'h00);
      $display("test freeze and boundaries done");

      wreg(`TCP_ADDR_POLARITY, 8'h00);
      for (i = 0; i < 4; i++) begin
         wreg(`TCP_ADDR_PRESCALE, 8'(i));
         start(0, 8'h04, 8'h01);
         measure(0, 4 << i, 3 << i);
      end
      wreg(`TCP_ADDR_PRESCALE, 8'h00);
      wreg(`TCP_ADDR_ENABLE, 8'h00);
      wreg(`TCP_ADDR_CONTROL, 8'h10);
      start(0, 8'h04, 8'h01);
      measure(0, 8, 6);
      $display("test prescale and center done");

      wreg(`TCP_ADDR_ENABLE, 8'h00);
      wreg(`TCP_ADDR_SCALE_A, 8'h02);
      wreg(`TCP_ADDR_CONTROL, 8'h01);
      start(0, 8'h04, 8'h01);
      measure(0, 16, 12);
      wreg(`TCP_ADDR_CONTROL, 8'h02);
      for (i = 0; i < 3; i++) begin
         s = (i == 0) ? 1 : (i == 1) ? int'($urandom_range(6, 2)) : 0;
         wreg(`TCP_ADDR_SCALE_B, 8'(s));
         start(1, 8'h02, 8'h01);
         if (s == 0)
            s = 256;
         measure(1, 4 * s, 2 * s);
      end
      $display("test scaled clocks done");
      idle(3);
      summarize();
   end
endmodule
